// *** inc/gtcc_pkg.sv ***
// constants, types and register map of the general timer core
//
// Function
// [RQ1] prescaler and counter advance only on falling edges of their clock
// [RQ2] reset forces prescaler to all ones and counter to zero
// [RQ3] counter loads reload on first edge after enable and after timeout
// [RQ4] prescaler divide-by-256 tap with counter forms one 24-bit counter
// [RQ5] timeout is detected when all sixteen counter bits are zero
// [RQ6] compare value is checked against counter; equality sets status flags (code ignores equality at count zero)
// [RQ7] first clock mux picks external clock or half the system clock
// [RQ8] second clock mux feeds counter from selected clock or prescaler output
// [RQ9] external clock is synchronised; each level lasts one clock period
// [RQ10] gate input is active low, synchronised, each level held one period
// [RQ11] interrupt line asserts while any unmasked expiry, gate, hit flag set
// [RQ12] output action field sets output idle level and event response
// [RQ13] software alters control register only while soft run bit is clear
// [RQ14] capture/compare mode operates when mode field holds 000
// [RQ15] enable and soft run set running flag, next edge loads reload value
// [RQ16] shadow copies counter after each decrement while gate flag clear
// [RQ17] gate rising edge sets gate flag, freezing shadow; write one clears
// [RQ18] with gate function disabled the gate input is ignored
// [RQ19] gate level flag always shows synchronised gate level
// [RQ20] capture mode keeps counting and reloading whatever the gate does
// [RQ21] compare equality sets hit and equal flags and acts on output (code ignores equality at count zero)
// [RQ22] zero sets expiry, clears equal flag, acts on output, then reloads
// [RQ23] output action is two bits: none, toggle, force zero, force one
package gtcc_pkg;
    // -----------------------------------------------------------------
    // register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] GTCC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] GTCC_ADDR_STAT = 8'h04;
    localparam logic [7:0] GTCC_ADDR_CMP = 8'h08;
    localparam logic [7:0] GTCC_ADDR_RELOAD = 8'h0c;
    localparam logic [7:0] GTCC_ADDR_SHADOW = 8'h10;
    // -----------------------------------------------------------------
    // field positions and reset values
    // -----------------------------------------------------------------
    localparam int GTCC_ST_EXPIRY = 1;
    localparam int GTCC_ST_GATE = 2;
    localparam int GTCC_ST_HIT = 3;
    localparam logic [7:0] GTCC_PSC_RESET = 8'hff;
    localparam logic [15:0] GTCC_CNT_RESET = 16'h0000;
    localparam logic [2:0] GTCC_MODE_CAPTURE = 3'h0;
    // -----------------------------------------------------------------
    // output action codes
    // -----------------------------------------------------------------
    localparam logic [1:0] GTCC_OA_NONE = 2'h0;
    localparam logic [1:0] GTCC_OA_TOGGLE = 2'h1;
    localparam logic [1:0] GTCC_OA_ZERO = 2'h2;
    localparam logic [1:0] GTCC_OA_ONE = 2'h3;
    // control register layout, msb first, bits 15:0
    typedef struct packed {
        logic [2:0] irq_mask_field;     // hit, gate, expiry
        logic [1:0] output_action_field;
        logic [2:0] mode;
        logic gate_function_enable;
        logic [2:0] prescale_tap;       // divide by 2**(tap+1)
        logic use_prescaler;
        logic ext_clock_select;
        logic prescale_count_enable;
        logic soft_run_bit;
    } gtcc_ctrl_type;
    // status register layout, msb first, bits 6:0
    typedef struct packed {
        logic out_level;
        logic gate_level_flag;
        logic compare_equal;
        logic compare_hit_flag;
        logic gate_event_flag;
        logic expiry_flag;
        logic running;
    } gtcc_stat_type;
endpackage : gtcc_pkg

// *** verilog/gtcc_timer.sv ***
// general timer core with capture/compare mode and apb register slave
`timescale 1ns/1ns
module gtcc_timer
    import gtcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins
    input wire logic external_count_clock_input,
    input wire logic gate_input_b,
    output logic waveform_output,
    // interrupt request
    output logic interrupt_request_line
);
    // all checks below run on the system clock, off during reset
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // -----------------------------------------------------------------
    // registers and state
    // -----------------------------------------------------------------
    gtcc_ctrl_type control_reg;
    gtcc_stat_type status_reg;
    logic [15:0] compare_value;
    logic [15:0] first_reload_value;
    logic [15:0] count_shadow;
    logic [15:0] counter;
    logic [7:0] prescaler;
    logic loaded;
    logic updated;
    logic half_system_clock;
    logic sel_prev;
    logic ext_s1, ext_s2;
    logic gate_s1, gate_s2, gate_s3;

    // -----------------------------------------------------------------
    // decode and selection
    // -----------------------------------------------------------------
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire wr_done = access_done & pwrite;
    wire hit_ctrl = paddr == GTCC_ADDR_CTRL;
    wire hit_stat = paddr == GTCC_ADDR_STAT;
    wire hit_cmp = paddr == GTCC_ADDR_CMP;
    wire hit_reload = paddr == GTCC_ADDR_RELOAD;
    wire hit_shadow = paddr == GTCC_ADDR_SHADOW;
    wire mapped = hit_ctrl | hit_stat | hit_cmp | hit_reload | hit_shadow;
    wire [6:0] w1c = (wr_done & hit_stat) ? pwdata[6:0] : 7'h00;
    // [RQ14] capture mode only
    wire mode_ok = control_reg.mode == GTCC_MODE_CAPTURE;
    // [RQ15] enable term
    wire run = control_reg.soft_run_bit & control_reg.prescale_count_enable
        & mode_ok;
    // [RQ7] first clock multiplexer
    wire sel_clk = control_reg.ext_clock_select ? ext_s2 : half_system_clock;
    // [RQ1] falling edge of the selected clock
    wire sel_fall = sel_prev & ~sel_clk;
    wire [7:0] psc_dec = prescaler - 8'h01;
    wire psc_tap_now = prescaler[control_reg.prescale_tap];
    wire psc_tap_next = psc_dec[control_reg.prescale_tap];
    // [RQ4] tap falls when its bit drops; tap 7 chains a 24-bit count
    wire psc_fall = sel_fall & psc_tap_now & ~psc_tap_next;
    // [RQ8] second clock multiplexer
    wire cnt_fall = run & (control_reg.use_prescaler ? psc_fall : sel_fall);
    // [RQ5] timeout when all sixteen stages are zero
    wire at_zero = counter == 16'h0000;
    wire timeout_evt = updated & at_zero;
    // [RQ6] exact compare, checked on each new nonzero count value
    wire hit_evt = updated & (counter == compare_value) & ~at_zero;
    // [RQ17] gate negation edge, [RQ18] ignored unless enabled
    wire gate_rise = gate_s2 & ~gate_s3 & control_reg.gate_function_enable
        & mode_ok;
    wire oa_zero = control_reg.output_action_field == GTCC_OA_ZERO;
    wire [2:0] irq_src = {status_reg.compare_hit_flag,
        status_reg.gate_event_flag, status_reg.expiry_flag};
    // [RQ12] idle level: high for force-zero action, low otherwise
    wire idle_level = oa_zero;

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    // [RQ9] [RQ10] two flops before any logic reads a pin
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            gate_s1 <= 1'b1;
            gate_s2 <= 1'b1;
            gate_s3 <= 1'b1;
        end else begin
            ext_s1 <= external_count_clock_input;
            ext_s2 <= ext_s1;
            gate_s1 <= gate_input_b;
            gate_s2 <= gate_s1;
            gate_s3 <= gate_s2;
        end
    end

    // half clock and edge history of the selected clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            half_system_clock <= 1'b0;
            sel_prev <= 1'b0;
        end else begin
            half_system_clock <= ~half_system_clock;
            sel_prev <= sel_clk;
        end
    end

    // -----------------------------------------------------------------
    // prescaler and counter
    // -----------------------------------------------------------------
    // [RQ2] [RQ1] prescaler held at all ones while stopped
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prescaler <= GTCC_PSC_RESET;
        end else if (!run) begin
            prescaler <= GTCC_PSC_RESET;
        end else if (sel_fall) begin
            prescaler <= psc_dec;
        end
    end

    // [RQ3] [RQ20] [RQ22] load on first edge and after timeout
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            counter <= GTCC_CNT_RESET;
            loaded <= 1'b0;
            updated <= 1'b0;
        end else begin
            updated <= cnt_fall;
            if (!run) begin
                loaded <= 1'b0;
            end else if (cnt_fall) begin
                loaded <= 1'b1;
                counter <= (!loaded || at_zero) ? first_reload_value
                    : counter - 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------------
    // shadow, status and output
    // -----------------------------------------------------------------
    // [RQ16] shadow follows counter until the gate flag freezes it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_shadow <= GTCC_CNT_RESET;
        end else if (updated && !status_reg.gate_event_flag) begin
            count_shadow <= counter;
        end
    end

    // sticky flags: a set in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= '0;
        end else begin
            // [RQ15] running flag
            status_reg.running <= run;
            // [RQ22] expiry flag
            status_reg.expiry_flag <= timeout_evt
                | (status_reg.expiry_flag & ~w1c[GTCC_ST_EXPIRY]);
            // [RQ17] gate event flag
            status_reg.gate_event_flag <= gate_rise
                | (status_reg.gate_event_flag & ~w1c[GTCC_ST_GATE]);
            // [RQ21] hit flag
            status_reg.compare_hit_flag <= hit_evt
                | (status_reg.compare_hit_flag & ~w1c[GTCC_ST_HIT]);
            // [RQ21] [RQ22] equal flag set on match, cleared by timeout
            if (hit_evt) begin
                status_reg.compare_equal <= 1'b1;
            end else if (timeout_evt || !run) begin
                status_reg.compare_equal <= 1'b0;
            end
            // [RQ19] gate level always visible, active low pin inverted
            status_reg.gate_level_flag <= ~gate_s2;
            status_reg.out_level <= waveform_output;
        end
    end

    // [RQ12] [RQ23] waveform output response
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            waveform_output <= 1'b0;
        end else if (!run) begin
            waveform_output <= idle_level;
        end else if (hit_evt || timeout_evt) begin
            unique case (control_reg.output_action_field)
                GTCC_OA_NONE: waveform_output <= waveform_output;
                GTCC_OA_TOGGLE: waveform_output <= ~waveform_output;
                GTCC_OA_ZERO: waveform_output <= ~hit_evt;
                GTCC_OA_ONE: waveform_output <= hit_evt;
            endcase
        end
    end

    // [RQ11] masked flags drive the interrupt line
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            interrupt_request_line <= 1'b0;
        end else begin
            interrupt_request_line <= |(irq_src & control_reg.irq_mask_field);
        end
    end

    // -----------------------------------------------------------------
    // apb slave
    // -----------------------------------------------------------------
    // [RQ13] control writes while running are accepted; results undefined
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_reg <= '0;
            compare_value <= 16'h0000;
            first_reload_value <= 16'h0000;
        end else if (wr_done) begin
            if (hit_ctrl) control_reg <= pwdata[15:0];
            if (hit_cmp) compare_value <= pwdata[15:0];
            if (hit_reload) first_reload_value <= pwdata[15:0];
        end
    end

    // no wait state: read data captured in setup, ready in access
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            if (setup_phase) begin
                prdata <= hit_ctrl ? {16'h0000, control_reg}
                    : hit_stat ? {25'h0000000, status_reg}
                    : hit_cmp ? {16'h0000, compare_value}
                    : hit_reload ? {16'h0000, first_reload_value}
                    : hit_shadow ? {16'h0000, count_shadow}
                    : 32'h0000_0000;
            end
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_answer_s;
        pready ##1 !pready;
    endsequence

    bus_answer_a: assert property ( // apb ready one cycle after setup
        apb_setup_s |=> apb_answer_s)
        else $error("apb answer not one cycle after setup");
    psc_idle_a: assert property ( // [RQ2]
        !run |=> prescaler == 8'hff)
        else $error("prescaler not all ones while stopped");
    first_load_a: assert property ( // [RQ15]
        run && !loaded && cnt_fall |=> counter == $past(first_reload_value))
        else $error("first edge did not load reload value");
    count_down_a: assert property ( // [RQ1]
        run && loaded && cnt_fall && !at_zero
        |=> counter == $past(counter) - 16'h0001 ##1 $stable(counter))
        else $error("counter did not step down by one");
    expiry_set_a: assert property ( // [RQ22]
        updated && at_zero && run
        |=> status_reg.expiry_flag && !status_reg.compare_equal)
        else $error("timeout did not set expiry and clear equal");
    hit_set_a: assert property ( // [RQ21]
        hit_evt |=> status_reg.compare_hit_flag && status_reg.compare_equal)
        else $error("compare match flags not set");
    shadow_copy_a: assert property ( // [RQ16]
        updated && !status_reg.gate_event_flag
        |=> count_shadow == $past(counter))
        else $error("shadow missed a counter update");
    shadow_freeze_a: assert property ( // [RQ17]
        status_reg.gate_event_flag |=> $stable(count_shadow))
        else $error("shadow moved while frozen");
    gate_off_a: assert property ( // [RQ18]
        !control_reg.gate_function_enable && !status_reg.gate_event_flag
        |=> !status_reg.gate_event_flag)
        else $error("gate flag set with gate disabled");
    irq_out_a: assert property ( // [RQ11]
        (irq_src & control_reg.irq_mask_field) != 3'h0
        |=> interrupt_request_line)
        else $error("unmasked flag did not raise interrupt");
endmodule : gtcc_timer

// *** tb/gtcc_apb_master.sv ***
// apb master model standing in for the processor core
`timescale 1ns/1ns
module gtcc_apb_master (
    // clock
    input wire logic sys_clk,
    // request side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // answer side
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = (n < 50) ? prdata : 'x;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows inverted address and data, pwrite keeps its stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : gtcc_apb_master

// *** tb/tb_general_timer_capture_compare.sv ***
// self-checking testbench of the general timer core
`timescale 1ns/1ns
module tb_general_timer_capture_compare import gtcc_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, s1, s2;
    logic ext_clk = 1'b0;
    logic gate_b = 1'b1;
    logic wave, irq, e;
    logic [1:0] ecnt = 2'h0;
    logic [15:0] cur = 16'h0;
    int mismatches = 0;
    int cmp_count = 0;
    int n;
    logic [15:0] cfg [4] = '{16'h3800, 16'h1004, 16'h0808, 16'h1878};
    int k [4] = '{2, 6, 4, 512};
    logic lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

    always #50 sys_clk = ~sys_clk;
    // external clock, each level three cycles
    always @(posedge sys_clk) begin
        ecnt <= (ecnt == 2'h2) ? 2'h0 : ecnt + 2'h1;
        if (ecnt == 2'h2) ext_clk <= ~ext_clk;
    end

    gtcc_timer DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_clock_input(ext_clk),
        .gate_input_b(gate_b), .waveform_output(wave),
        .interrupt_request_line(irq));
    gtcc_apb_master bus (.sys_clk(sys_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ----------------------------------------------------------------
    // helper tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        bus.xfer(1'b1, a, d, r, x);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic x;
        bus.xfer(1'b0, a, 32'h0, r, x);
    endtask : rd
    // clear only the run bit so nothing else moves while running
    task automatic stop;
        cur = cur & 16'hfffe;
        wr(GTCC_ADDR_CTRL, {16'h0, cur});
    endtask : stop
    task automatic start(input logic [15:0] c);
        wr(GTCC_ADDR_CTRL, {16'h0, c});
        cur = c | 16'h0003;
        wr(GTCC_ADDR_CTRL, {16'h0, cur});
    endtask : start
    // cycles until the waveform output changes, bounded
    task automatic wait_change(output int cnt);
        logic v;
        v = wave;
        cnt = 0;
        do begin
            @(negedge sys_clk);
            cnt++;
        end while (wave === v && cnt < 6000);
    endtask : wait_change
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        #(40000 * 100);
        mismatches++;
        results();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(GTCC_ADDR_SHADOW, q);
        chk("shadow after reset", q, 32'h0);
        rd(GTCC_ADDR_STAT, q);
        chk("status after reset", q, 32'h0);
        chk("irq after reset", irq, 1'b0);
        bus.xfer(1'b0, 8'h14, 32'h0, q, e);
        chk("unmapped error", e, 1'b1);
        chk("unmapped data", q, 32'h0);
        wr(GTCC_ADDR_CMP, 32'h3);
        wr(GTCC_ADDR_RELOAD, 32'h8);
        rd(GTCC_ADDR_CMP, q);
        chk("compare value", q, 32'h3);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            stop();
            start(cfg[i]);
            wait_change(n);
            if (cfg[i][12:11] != GTCC_OA_TOGGLE) begin
                chk("level at hit", wave, lvl[i]);
            end
            wait_change(n);
            chk("hit to expiry", n, 3 * k[i]);
            wait_change(n);
            chk("expiry to hit", n, 6 * k[i]);
            if (i == 0) begin
                rd(GTCC_ADDR_STAT, q);
                chk("status at hit", q, 32'h5b);
                chk("irq expiry", irq, 1'b1);
                wait_change(n);
                rd(GTCC_ADDR_STAT, q);
                chk("status at expiry", q, 32'h0b);
                stop();
                wr(GTCC_ADDR_STAT, 32'he);
                rd(GTCC_ADDR_STAT, q);
                chk("flags cleared", q, 32'h0);
                chk("irq cleared", irq, 1'b0);
            end
            $display("test clock setup %0d done", i);
        end
        stop();
        start(16'h4080);
        // gate levels held at least four system clocks each
        gate_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(GTCC_ADDR_STAT, q);
        chk("gate level", q[5], 1'b1);
        chk("no early event", q[2], 1'b0);
        gate_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(GTCC_ADDR_STAT, q);
        chk("gate event", q[2], 1'b1);
        chk("gate irq", irq, 1'b1);
        rd(GTCC_ADDR_SHADOW, s1);
        repeat (5) @(posedge sys_clk);
        rd(GTCC_ADDR_SHADOW, s2);
        chk("frozen shadow", s2 === s1, 1'b1);
        wr(GTCC_ADDR_STAT, 32'h4);
        rd(GTCC_ADDR_SHADOW, s1);
        rd(GTCC_ADDR_SHADOW, s2);
        chk("moving shadow", s2 === s1, 1'b0);
        chk("gate irq cleared", irq, 1'b0);
        $display("test gate capture done");
        stop();
        start(16'h4000);
        gate_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        gate_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(GTCC_ADDR_STAT, q);
        chk("gate ignored", q[2], 1'b0);
        stop();
        start(16'h0100);
        repeat (4) @(posedge sys_clk);
        rd(GTCC_ADDR_STAT, q);
        chk("other mode idle", q[0], 1'b0);
        $display("test gate off and mode done");
        results();
    end
endmodule : tb_general_timer_capture_compare
